// >>> hdl/epp_port_regs.svh
// register offsets, field positions, codes and timing for the parallel port
`ifndef EPP_PORT_REGS_SVH
`define EPP_PORT_REGS_SVH

`define EPP_OFF_DATA        3'h0
`define EPP_OFF_STATUS      3'h1
`define EPP_OFF_CTRL        3'h2
`define EPP_OFF_ADDR_WIN    3'h3
`define EPP_OFF_DATA_WIN0   3'h4
`define EPP_OFF_DATA_WIN3   3'h7

`define EPP_CTRL_STROBE     0
`define EPP_CTRL_LINE_FEED  1
`define EPP_CTRL_INIT       2
`define EPP_CTRL_SELECT     3
`define EPP_CTRL_IRQ_EN     4
`define EPP_CTRL_DIR        5
`define EPP_CTRL_WIDTH      6
`define EPP_CTRL_RESET      6'h00

`define EPP_STAT_TIMEOUT    0
`define EPP_STAT_ERROR      3
`define EPP_STAT_SELECT     4
`define EPP_STAT_PAPER_END  5
`define EPP_STAT_ACK        6
`define EPP_STAT_READY      7

`define EPP_BYTE_RESET      8'h00
`define EPP_BYTE_ABORT      8'hFF

`define EPP_MODE_PRINTER    2'h0
`define EPP_MODE_BIDIR      2'h1
`define EPP_MODE_EPP19      2'h2
`define EPP_MODE_EPP17      2'h3

`define EPP_LPC_START       4'h0
`define EPP_LPC_IO_READ     4'h0
`define EPP_LPC_IO_WRITE    4'h2
`define EPP_LPC_SYNC_READY  4'h0
`define EPP_LPC_SYNC_LONG   4'h6
`define EPP_LPC_TAR_LEVEL   4'hF
`define EPP_LPC_LAST_ADDR   2'h3
`define EPP_LPC_BASE_LSB    3

`define EPP_CLK_PERIOD_NS   40
`define EPP_WATCHDOG_NS     10000
`define EPP_WATCHDOG_CYCLES (`EPP_WATCHDOG_NS / `EPP_CLK_PERIOD_NS)
`define EPP_WD_WIDTH        8

`define EPP_SYNC_WIDTH      13

`endif

// >>> hdl/epp_pkg.sv
// types shared by the parallel port logic
`include "epp_port_regs.svh"

package epp_pkg;

  typedef enum logic [2:0] {
    LPC_IDLE,
    LPC_CYCTYPE,
    LPC_ADDR,
    LPC_WDATA,
    LPC_TAR_IN,
    LPC_SYNC,
    LPC_RDATA,
    LPC_TAR_OUT
  } epp_lpc_state_type;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_WAIT_LOW,
    CYC_SETUP,
    CYC_PHASE
  } epp_cyc_state_type;

  typedef struct packed {
    epp_lpc_state_type        lst;
    logic [1:0]               cnt;
    logic                     is_write;
    logic [15:0]              addr;
    logic [7:0]               wdata;
    logic [7:0]               rdata;
    logic [3:0]               ad_out;
    logic                     ad_oe_n;
    logic [7:0]               data_reg;
    logic [`EPP_CTRL_WIDTH-1:0] ctrl;
    logic [7:0]               addr_win;
    logic [7:0]               data_win;
    epp_cyc_state_type        est;
    logic                     epp_read;
    logic                     epp_addr;
    logic [`EPP_WD_WIDTH-1:0] wd;
    logic                     timeout;
    logic                     ack_prev;
    logic                     irq;
    logic [7:0]               pd_out;
    logic                     pd_oe_n;
    logic                     strobe_pin;
    logic                     line_feed_pin;
    logic                     init_pin;
    logic                     select_pin;
  } epp_state_type;

endpackage : epp_pkg

// >>> hdl/epp_pin_sync.sv
// two-stage synchroniser for the parallel port pin inputs
`timescale 1ns/1ns
`default_nettype none
`include "epp_port_regs.svh"

module epp_pin_sync (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic [`EPP_SYNC_WIDTH-1:0] pins_in,
  output var  logic [`EPP_SYNC_WIDTH-1:0] pins_out
);

  logic [`EPP_SYNC_WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q   <= '0;
      pins_out <= '0;
    end
    else
    begin
      meta_q   <= pins_in;
      pins_out <= meta_q;
    end
  end

endmodule : epp_pin_sync

`default_nettype wire

// >>> hdl/epp_parallel_port_ctrl.sv
// parallel port with compatible, bidirectional and enhanced (1.9 / 1.7) handshakes behind LPC I/O
`timescale 1ns/1ns
`default_nettype none
`include "epp_port_regs.svh"

module epp_parallel_port_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        lpc_frame_n,
  input  wire logic [3:0]  lpc_ad_in,
  output var  logic [3:0]  lpc_ad_out,
  output var  logic        lpc_ad_oe_n,
  input  wire logic [15:0] io_base,
  input  wire logic [1:0]  port_mode,
  input  wire logic        timeout_select,
  input  wire logic [7:0]  peripheral_byte_bus_in,
  output var  logic [7:0]  peripheral_byte_bus_out,
  output var  logic        peripheral_byte_bus_oe_n,
  input  wire logic        peripheral_hold_line,
  input  wire logic        peripheral_ack_line,
  input  wire logic        error_n_pin,
  input  wire logic        select_status_pin,
  input  wire logic        paper_end_pin,
  output var  logic        host_strobe_pin,
  output var  logic        line_feed_auto_pin,
  output var  logic        printer_initialize_line,
  output var  logic        select_printer_pin,
  output var  logic        port_irq
);

  epp_pkg::epp_state_type q;
  epp_pkg::epp_state_type n;

  logic [`EPP_SYNC_WIDTH-1:0] pins_raw;
  logic [`EPP_SYNC_WIDTH-1:0] pins_s;
  logic [7:0]                 pd_s;
  logic                       hold_s;
  logic                       ack_s;
  logic                       err_s;
  logic                       slct_s;
  logic                       pe_s;

  assign pins_raw = {peripheral_byte_bus_in, peripheral_hold_line, peripheral_ack_line,
                     error_n_pin, select_status_pin, paper_end_pin};

  epp_pin_sync u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .pins_in  (pins_raw),
    .pins_out (pins_s)
  );

  assign pd_s   = pins_s[12:5];
  assign hold_s = pins_s[4];
  assign ack_s  = pins_s[3];
  assign err_s  = pins_s[2];
  assign slct_s = pins_s[1];
  assign pe_s   = pins_s[0];

  function automatic logic is_epp_mode(input logic [1:0] mode);
    is_epp_mode = (mode == `EPP_MODE_EPP19) || (mode == `EPP_MODE_EPP17);
  endfunction : is_epp_mode

  function automatic logic is_window(input logic [2:0] off);
    is_window = (off >= `EPP_OFF_ADDR_WIN);
  endfunction : is_window

  function automatic logic [7:0] status_byte(input logic tmo, input logic err, input logic slct,
                                             input logic pe, input logic ack, input logic hold);
    status_byte                     = 8'h00;
    status_byte[`EPP_STAT_TIMEOUT]  = tmo;
    status_byte[`EPP_STAT_ERROR]    = err;
    status_byte[`EPP_STAT_SELECT]   = slct;
    status_byte[`EPP_STAT_PAPER_END] = pe;
    status_byte[`EPP_STAT_ACK]      = ack;
    status_byte[`EPP_STAT_READY]    = ~hold;
  endfunction : status_byte

  logic       start_cyc;
  logic       start_addr;
  logic       start_rd;
  logic       hit;
  logic       in_cycle;
  logic       drive_bus;
  logic [2:0] off;

  always_comb
  begin
    n          = q;
    start_cyc  = 1'b0;
    start_addr = 1'b0;
    start_rd   = 1'b0;
    off        = q.addr[2:0];
    hit        = (q.addr[15:`EPP_LPC_BASE_LSB] == io_base[15:`EPP_LPC_BASE_LSB]) &&
                 (!is_window(off) || is_epp_mode(port_mode));

    // LPC target side
    case (q.lst)
      epp_pkg::LPC_IDLE:
      begin
        n.ad_oe_n = 1'b1;
      end
      epp_pkg::LPC_CYCTYPE:
      begin
        n.cnt = 2'h0;
        if (lpc_ad_in == `EPP_LPC_IO_READ)
        begin
          n.is_write = 1'b0;
          n.lst      = epp_pkg::LPC_ADDR;
        end
        else if (lpc_ad_in == `EPP_LPC_IO_WRITE)
        begin
          n.is_write = 1'b1;
          n.lst      = epp_pkg::LPC_ADDR;
        end
        else
        begin
          n.lst = epp_pkg::LPC_IDLE;
        end
      end
      epp_pkg::LPC_ADDR:
      begin
        n.addr = {q.addr[11:0], lpc_ad_in};
        n.cnt  = q.cnt + 2'h1;
        if (q.cnt == `EPP_LPC_LAST_ADDR)
        begin
          n.cnt = 2'h0;
          n.lst = q.is_write ? epp_pkg::LPC_WDATA : epp_pkg::LPC_TAR_IN;
        end
      end
      epp_pkg::LPC_WDATA:
      begin
        n.cnt = q.cnt + 2'h1;
        if (q.cnt == 2'h0)
        begin
          n.wdata[3:0] = lpc_ad_in;
        end
        else
        begin
          n.wdata[7:4] = lpc_ad_in;
          n.cnt        = 2'h0;
          n.lst        = epp_pkg::LPC_TAR_IN;
        end
      end
      epp_pkg::LPC_TAR_IN:
      begin
        n.cnt = q.cnt + 2'h1;
        if (q.cnt != 2'h0)
        begin
          n.cnt = 2'h0;
          if (!hit)
          begin
            // unclaimed address: no sync, host sees an abort
            n.lst = epp_pkg::LPC_IDLE;
          end
          else
          begin
            n.lst     = epp_pkg::LPC_SYNC;
            n.ad_oe_n = 1'b0;
            n.ad_out  = is_window(off) ? `EPP_LPC_SYNC_LONG : `EPP_LPC_SYNC_READY;
            if (is_window(off))
            begin
              start_cyc  = 1'b1;
              start_addr = (off == `EPP_OFF_ADDR_WIN);
              start_rd   = !q.is_write;
              if (q.is_write && start_addr)
              begin
                n.addr_win = q.wdata;
              end
              else if (q.is_write)
              begin
                n.data_win = q.wdata;
              end
            end
            else if (q.is_write)
            begin
              case (off)
                `EPP_OFF_DATA:   n.data_reg = q.wdata;
                `EPP_OFF_CTRL:   n.ctrl = q.wdata[`EPP_CTRL_WIDTH-1:0];
                `EPP_OFF_STATUS:
                begin
                  if (timeout_select && q.wdata[`EPP_STAT_TIMEOUT])
                  begin
                    n.timeout = 1'b0;
                  end
                end
                default:         n.data_reg = q.data_reg;
              endcase
            end
            else
            begin
              case (off)
                `EPP_OFF_DATA:   n.rdata = pd_s;
                `EPP_OFF_STATUS: n.rdata = status_byte(q.timeout, err_s, slct_s, pe_s, ack_s, hold_s);
                `EPP_OFF_CTRL:   n.rdata = {{(8-`EPP_CTRL_WIDTH){1'b0}}, q.ctrl};
                default:         n.rdata = `EPP_BYTE_ABORT;
              endcase
            end
          end
        end
      end
      epp_pkg::LPC_SYNC:
      begin
        if (q.ad_out == `EPP_LPC_SYNC_READY)
        begin
          n.cnt    = 2'h0;
          n.lst    = q.is_write ? epp_pkg::LPC_TAR_OUT : epp_pkg::LPC_RDATA;
          n.ad_out = q.is_write ? `EPP_LPC_TAR_LEVEL : q.rdata[3:0];
        end
        else
        begin
          // long waits stretch the host cycle until the handshake is over
          n.ad_out = (q.est == epp_pkg::CYC_IDLE) ? `EPP_LPC_SYNC_READY : `EPP_LPC_SYNC_LONG;
        end
      end
      epp_pkg::LPC_RDATA:
      begin
        n.cnt    = 2'h1;
        n.ad_out = q.rdata[7:4];
        if (q.cnt != 2'h0)
        begin
          n.cnt    = 2'h0;
          n.lst    = epp_pkg::LPC_TAR_OUT;
          n.ad_out = `EPP_LPC_TAR_LEVEL;
        end
      end
      epp_pkg::LPC_TAR_OUT:
      begin
        n.cnt     = 2'h1;
        n.ad_oe_n = 1'b1;
        if (q.cnt != 2'h0)
        begin
          n.lst = epp_pkg::LPC_IDLE;
          if (!q.is_write && off == `EPP_OFF_STATUS)
          begin
            n.irq = 1'b0;
            if (!timeout_select)
            begin
              n.timeout = 1'b0;
            end
          end
        end
      end
      default:
      begin
        n.lst = epp_pkg::LPC_IDLE;
      end
    endcase

    // a frame start restarts the decoder from anywhere
    if (!lpc_frame_n)
    begin
      n.lst     = (lpc_ad_in == `EPP_LPC_START) ? epp_pkg::LPC_CYCTYPE : epp_pkg::LPC_IDLE;
      n.ad_oe_n = 1'b1;
    end

    // enhanced handshake engine
    n.wd = q.wd + 8'h01;
    case (q.est)
      epp_pkg::CYC_IDLE:
      begin
        n.wd = '0;
        if (start_cyc)
        begin
          n.epp_addr = start_addr;
          // a set direction bit, with the strobe bit clear, turns a write into a read, silently
          n.epp_read = start_rd || (q.ctrl[`EPP_CTRL_DIR] && !q.ctrl[`EPP_CTRL_STROBE]);
          n.est      = (port_mode == `EPP_MODE_EPP19 && hold_s) ? epp_pkg::CYC_WAIT_LOW
                                                                 : epp_pkg::CYC_SETUP;
        end
      end
      epp_pkg::CYC_WAIT_LOW:
      begin
        if (!hold_s)
        begin
          n.est = epp_pkg::CYC_SETUP;
        end
      end
      epp_pkg::CYC_SETUP:
      begin
        n.est = epp_pkg::CYC_PHASE;
      end
      epp_pkg::CYC_PHASE:
      begin
        if (hold_s)
        begin
          n.est = epp_pkg::CYC_IDLE;
          if (q.epp_read)
          begin
            n.rdata = pd_s;
          end
        end
      end
      default:
      begin
        n.est = epp_pkg::CYC_IDLE;
      end
    endcase
    // one count serves both variants; only the start of the wait differs
    if (q.est != epp_pkg::CYC_IDLE && q.wd == 8'(`EPP_WATCHDOG_CYCLES))
    begin
      n.est     = epp_pkg::CYC_IDLE;
      n.timeout = 1'b1;
      if (q.epp_read)
      begin
        n.rdata = `EPP_BYTE_ABORT;
      end
    end

    // acknowledge interrupt; the set beats a same-cycle status-read clear, but a clear enable bit beats the set
    n.ack_prev = ack_s;
    if (!q.ctrl[`EPP_CTRL_IRQ_EN])
    begin
      n.irq = 1'b0;
    end
    else if (ack_s && !q.ack_prev)
    begin
      n.irq = 1'b1;
    end

    // pins
    in_cycle = (n.est == epp_pkg::CYC_SETUP) || (n.est == epp_pkg::CYC_PHASE);
    if (in_cycle)
    begin
      drive_bus       = !n.epp_read || n.ctrl[`EPP_CTRL_STROBE];
      n.strobe_pin    = !drive_bus;
      n.line_feed_pin = !(n.est == epp_pkg::CYC_PHASE && !n.epp_addr);
      n.select_pin    = !(n.est == epp_pkg::CYC_PHASE && n.epp_addr);
      n.pd_out        = n.epp_addr ? n.addr_win : n.data_win;
    end
    else
    begin
      drive_bus       = (port_mode == `EPP_MODE_PRINTER) || !n.ctrl[`EPP_CTRL_DIR];
      n.strobe_pin    = ~n.ctrl[`EPP_CTRL_STROBE];
      n.line_feed_pin = ~n.ctrl[`EPP_CTRL_LINE_FEED];
      n.select_pin    = ~n.ctrl[`EPP_CTRL_SELECT];
      n.pd_out        = n.data_reg;
    end
    n.init_pin = n.ctrl[`EPP_CTRL_INIT];
    n.pd_oe_n  = !drive_bus;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      q               <= '0;
      q.lst           <= epp_pkg::LPC_IDLE;
      q.est           <= epp_pkg::CYC_IDLE;
      q.ad_oe_n       <= 1'b1;
      q.ctrl          <= `EPP_CTRL_RESET;
      q.data_reg      <= `EPP_BYTE_RESET;
      q.addr_win      <= `EPP_BYTE_RESET;
      q.data_win      <= `EPP_BYTE_RESET;
      q.timeout       <= 1'b0;
      q.pd_oe_n       <= 1'b0;
      q.strobe_pin    <= 1'b1;
      q.line_feed_pin <= 1'b1;
      q.select_pin    <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign lpc_ad_out               = q.ad_out;
  assign lpc_ad_oe_n              = q.ad_oe_n;
  assign peripheral_byte_bus_out  = q.pd_out;
  assign peripheral_byte_bus_oe_n = q.pd_oe_n;
  assign host_strobe_pin          = q.strobe_pin;
  assign line_feed_auto_pin       = q.line_feed_pin;
  assign printer_initialize_line  = q.init_pin;
  assign select_printer_pin       = q.select_pin;
  assign port_irq                 = q.irq;

endmodule : epp_parallel_port_ctrl

`default_nettype wire

// >>> dv/epp_port_asserts.sv
// concurrent checks on the parallel port top-level ports
`timescale 1ns/1ns
`default_nettype none
`include "epp_port_regs.svh"
module epp_port_asserts (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [1:0] port_mode,
  input wire logic       peripheral_hold_line,
  input wire logic       peripheral_ack_line,
  input wire logic [3:0] lpc_ad_out,
  input wire logic       lpc_ad_oe_n,
  input wire logic       peripheral_byte_bus_oe_n,
  input wire logic       host_strobe_pin,
  input wire logic       line_feed_auto_pin,
  input wire logic       select_printer_pin,
  input wire logic       port_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       long_w;
  logic [8:0] long_q;
  assign long_w = !lpc_ad_oe_n && lpc_ad_out == `EPP_LPC_SYNC_LONG;
  // run length of wait syncs, bounds the watchdog from outside
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      long_q <= 9'h000;
    else
      long_q <= long_w ? long_q + 9'h001 : 9'h000;
  sequence s_hold_low;
    (!peripheral_hold_line)[*3];
  endsequence
  sequence s_data_phase;
    long_w && !line_feed_auto_pin && long_q < 9'h0C8;
  endsequence
  a_idle_after_reset: assert property ($fell(reset) |-> lpc_ad_oe_n && !port_irq)
    else $error("bus or interrupt active after reset");
  a_tar_before_release: assert property ($rose(lpc_ad_oe_n) |-> $past(lpc_ad_out) == `EPP_LPC_TAR_LEVEL)
    else $error("bus released without turnaround");
  a_wait_sync_bound: assert property (long_q <= 9'h104)
    else $error("wait syncs outlast watchdog");
  a_phase_holds: assert property (s_hold_low ##0 s_data_phase |=> !line_feed_auto_pin)
    else $error("phase ended while peripheral held");
  a_read_floats: assert property (long_w && !line_feed_auto_pin && host_strobe_pin |-> peripheral_byte_bus_oe_n)
    else $error("data pins driven during read phase");
  a_write_drives: assert property (long_w && !(line_feed_auto_pin && select_printer_pin) && !host_strobe_pin
    |-> !peripheral_byte_bus_oe_n)
    else $error("data pins released during write phase");
  a_one_phase: assert property (long_w |-> line_feed_auto_pin || select_printer_pin)
    else $error("address and data phase together");
  a_irq_after_ack: assert property ($rose(port_irq) |-> $past(peripheral_ack_line))
    else $error("interrupt without acknowledge");
  a_printer_drives: assert property ((port_mode == `EPP_MODE_PRINTER)[*2] |-> !peripheral_byte_bus_oe_n)
    else $error("printer mode released data pins");
endmodule : epp_port_asserts
`default_nettype wire

// >>> dv/epp_periph_model.sv
// behavioural peripheral on the far side of the enhanced port
`timescale 1ns/1ns
`default_nettype none
module epp_periph_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] dev_byte,
  input  wire logic       dev_oe_n,
  input  wire logic       data_phase_n,
  input  wire logic       addr_phase_n,
  input  wire logic [7:0] reply,
  input  wire logic [3:0] delay,
  input  wire logic       stuck,
  input  wire logic       busy,
  output var  logic       hold,
  output var  logic [7:0] bus,
  output var  logic [7:0] got,
  output var  logic       got_addr,
  output var  logic       got_wr
);
  logic       hold_q = 1'b0;
  logic       drv_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [3:0] n_q = 4'h0;
  wire        phase = !data_phase_n || !addr_phase_n;
  assign hold = hold_q || busy;
  // released lines show the inverse of the last level, never a stale byte
  assign bus = !dev_oe_n ? dev_byte : drv_q ? reply : ~last_q;
  always @(posedge sys_clk)
  begin
    last_q <= bus;
    if (phase && !hold_q)
    begin
      drv_q <= dev_oe_n;
      n_q <= n_q + 4'h1;
      if (n_q >= delay && !stuck)
      begin
        hold_q <= 1'b1;
        got <= bus;
        got_addr <= !addr_phase_n;
        got_wr <= !dev_oe_n;
      end
    end
    else if (!phase)
    begin
      hold_q <= 1'b0;
      drv_q <= 1'b0;
      n_q <= 4'h0;
    end
  end
endmodule : epp_periph_model
`default_nettype wire

// >>> dv/tb_top.sv
// testbench: LPC accesses against the parallel port and its peripheral model
`timescale 1ns/1ns
`default_nettype none
`include "epp_port_regs.svh"
module tb_top;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       frame_n = 1'b1;
  logic [3:0] ad_in = 4'hF;
  logic [1:0] mode = 2'h1;
  logic       tsel = 1'b0;
  logic       ack = 1'b0;
  logic       stuck = 1'b0;
  logic       busy = 1'b0;
  logic [7:0] reply = 8'h00;
  logic [3:0] ad_out;
  logic [7:0] pd_out, pd_in, got, rv;
  logic       ad_oe_n, pd_oe_n, hold, strobe_pin, lf_pin, init_pin, sel_pin, irq, got_addr, got_wr, okv;
  int         failures = 0;
  int         tests_run = 0;
  int         m, o, w;
  time        t0;
  localparam logic [15:0] base_addr = 16'h0278;
  epp_parallel_port_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .lpc_frame_n(frame_n), .lpc_ad_in(ad_in),
    .lpc_ad_out(ad_out), .lpc_ad_oe_n(ad_oe_n), .io_base(base_addr), .port_mode(mode), .timeout_select(tsel),
    .peripheral_byte_bus_in(pd_in), .peripheral_byte_bus_out(pd_out), .peripheral_byte_bus_oe_n(pd_oe_n),
    .peripheral_hold_line(hold), .peripheral_ack_line(ack), .error_n_pin(1'b1), .select_status_pin(1'b0),
    .paper_end_pin(1'b1), .host_strobe_pin(strobe_pin), .line_feed_auto_pin(lf_pin),
    .printer_initialize_line(init_pin), .select_printer_pin(sel_pin), .port_irq(irq));
  epp_periph_model i_periph (.sys_clk(sys_clk), .dev_byte(pd_out), .dev_oe_n(pd_oe_n), .data_phase_n(lf_pin),
    .addr_phase_n(sel_pin), .reply(reply), .delay(4'h2), .stuck(stuck), .busy(busy), .hold(hold), .bus(pd_in),
    .got(got), .got_addr(got_addr), .got_wr(got_wr));
  always #20 sys_clk = ~sys_clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task test_done;
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic lpc(input logic wr, input logic [2:0] off, input logic [7:0] wd, output logic [7:0] rd,
                     output logic ok);
    logic [15:0] a;
    a = {base_addr[15:3], off};
    rd = 8'h00;
    ok = 1'b0;
    @(posedge sys_clk) frame_n <= 1'b0;
    ad_in <= `EPP_LPC_START;
    @(posedge sys_clk) frame_n <= 1'b1;
    ad_in <= wr ? `EPP_LPC_IO_WRITE : `EPP_LPC_IO_READ;
    for (int i = 3; i >= 0; i--)
      @(posedge sys_clk) ad_in <= a[i*4+:4];
    for (int i = 0; i < 2 && wr; i++)
      @(posedge sys_clk) ad_in <= wd[i*4+:4];
    @(posedge sys_clk) ad_in <= 4'hF;
    @(posedge sys_clk);
    for (int i = 0; i < 300 && !ok; i++)
      @(posedge sys_clk) ok = ad_oe_n === 1'b0 && ad_out === `EPP_LPC_SYNC_READY;
    if (ok)
    begin
      for (int i = 0; i < 2 && !wr; i++)
        @(posedge sys_clk) rd[i*4+:4] = ad_out;
      @(posedge sys_clk) chk({12'h000, ad_out}, {12'h000, `EPP_LPC_TAR_LEVEL});
      @(posedge sys_clk) chk({15'h0000, ad_oe_n}, 16'h0001);
    end
  endtask : lpc
  task wr(input logic [2:0] off, input logic [7:0] d, input logic ok_e);
    lpc(1'b1, off, d, rv, okv);
    chk({15'h0000, okv}, {15'h0000, ok_e});
  endtask : wr
  task rd(input logic [2:0] off, input logic [7:0] e, input logic ok_e);
    lpc(1'b0, off, 8'h00, rv, okv);
    chk({15'h0000, okv}, {15'h0000, ok_e});
    if (okv)
      chk({8'h00, rv}, {8'h00, e});
  endtask : rd
  task pins(input logic [4:0] e);
    chk({11'h000, strobe_pin, lf_pin, init_pin, sel_pin, pd_oe_n}, {11'h000, e});
  endtask : pins
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pins(5'b11010);
    wr(3'h2, 8'hFF, 1'b1);
    rd(3'h2, 8'h3F, 1'b1);
    pins(5'b00101);
    mode <= `EPP_MODE_PRINTER;
    repeat (3) @(posedge sys_clk);
    pins(5'b00100);
    mode <= `EPP_MODE_BIDIR;
    wr(3'h2, 8'h10, 1'b1);
    ack <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0001);
    wr(3'h2, 8'h00, 1'b1);
    ack <= 1'b0;
    chk({15'h0000, irq}, 16'h0000);
    repeat (6) @(posedge sys_clk) ack <= 1'b1;
    chk({15'h0000, irq}, 16'h0000);
    busy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(3'h1, 8'h68, 1'b1);
    busy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(3'h1, 8'hE8, 1'b1);
    wr(3'h4, 8'h55, 1'b0);
    rd(3'h3, 8'h00, 1'b0);
    for (m = 2; m < 4; m++)
    begin
      mode <= 2'(m);
      wr(3'h2, 8'h04, 1'b1);
      for (o = 3; o < 8; o++)
      begin
        wr(3'(o), 8'hA0 + 8'(o), 1'b1);
        chk({6'h00, got_wr, got_addr, got}, {6'h00, 1'b1, o == 3, 8'hA0 + 8'(o)});
      end
      wr(3'h2, m == 3 ? 8'h24 : 8'h04, 1'b1);
      for (o = 3; o < 8; o++)
      begin
        reply <= 8'h30 + 8'(o);
        rd(3'(o), 8'h30 + 8'(o), 1'b1);
      end
      pins({4'hF, m == 3});
    end
    mode <= `EPP_MODE_EPP19;
    wr(3'h2, 8'h04, 1'b1);
    for (w = 0; w < 2; w++)
    begin
      busy <= 1'b1;
      fork
        lpc(w == 0, 3'h4, 8'h6B, rv, okv);
        begin
          repeat (20) @(posedge sys_clk);
          chk({14'h0000, lf_pin, sel_pin}, 16'h0003);
          busy <= 1'b0;
        end
      join
      chk({7'h00, got_wr, got}, w == 0 ? 16'h016B : 16'h0037);
      chk({7'h00, okv, rv}, w == 0 ? 16'h0100 : 16'h0137);
    end
    wr(3'h2, 8'h05, 1'b1);
    lpc(1'b0, 3'h4, 8'h00, rv, okv);
    chk({15'h0000, okv}, 16'h0001);
    chk({15'h0000, got_wr}, 16'h0001);
    wr(3'h2, 8'h24, 1'b1);
    wr(3'h4, 8'h99, 1'b1);
    chk({7'h00, got_wr, got}, 16'h0037);
    for (w = 0; w < 2; w++)
    begin
      mode <= 2'(w + 2);
      tsel <= 1'(w);
      stuck <= 1'b1;
      t0 = $time;
      rd(3'h4, `EPP_BYTE_ABORT, 1'b1);
      chk(16'((($time - t0) / 40 - 240) / 40), 16'h0000);
      stuck <= 1'b0;
      rd(3'h1, 8'hE9, 1'b1);
      rd(3'h1, w == 0 ? 8'hE8 : 8'hE9, 1'b1);
      wr(3'h1, 8'h01, 1'b1);
      rd(3'h1, 8'hE8, 1'b1);
    end
    wr(3'h2, 8'h2F, 1'b1);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk) reset <= 1'b0;
    mode <= `EPP_MODE_BIDIR;
    rd(3'h2, 8'h00, 1'b1);
    test_done();
  end
  initial
  begin
    #2000000;
    failures++;
    test_done();
  end
endmodule : tb_top
bind epp_parallel_port_ctrl epp_port_asserts i_chk (.sys_clk(sys_clk), .reset(reset), .port_mode(port_mode),
  .peripheral_hold_line(peripheral_hold_line), .peripheral_ack_line(peripheral_ack_line),
  .lpc_ad_out(lpc_ad_out), .lpc_ad_oe_n(lpc_ad_oe_n), .peripheral_byte_bus_oe_n(peripheral_byte_bus_oe_n),
  .host_strobe_pin(host_strobe_pin), .line_feed_auto_pin(line_feed_auto_pin),
  .select_printer_pin(select_printer_pin), .port_irq(port_irq));
`default_nettype wire
